// File: hdl/scb_regs.sv
// Purpose: system control registers: interrupt state, keyed reset control, low-power control
// Assumes: AHB-Lite slave, zero wait states, single word transfers, response always OKAY
// Notes: core state inputs are on SYS_CLK; the external event pin is synchronised
// Operation
// - flag bit 22 reads 1 when any interrupt other than NMI or fault is pending
// - bits 17:12 show highest pending enabled exception number, zero if none
// - bits 5:0 show active exception number, zero in Thread mode
// - control writes need key 05fa in bits 31:16; key bits read as zero
// - bit 15 reports data byte order, 0 little, 1 big
// - keyed write of 1 to bit 2 requests system reset; bit reads 0
// - bit 1 reserved for debug, reads 0, software writes 0
// - low-power bit 4 lets disabled interrupts wake the processor too
// - a new pending event wakes wait-for-event, else it is latched
// - the send-event instruction also wakes wait-for-event
// - low-power bit 2 selects sleep or deep sleep
// - low-power bit 1 enables sleep on return from handler to thread mode
// - writing 1 to bit 27 clears pendable-service pending; set only via bit 28
// - bit 26 sets and bit 25 clears tick pending; zero writes do nothing
`timescale 1ns/1ps
`include "scb_map.svh"
module scb_regs
  import scb_pkg::*;
#(
  parameter logic BYTE_ORDER = 1'b0
)
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic IRQ_PENDING_ANY,
  input wire logic IRQ_PENDING_DISABLED,
  input wire logic [5:0] PENDING_VECTOR,
  input wire logic [5:0] ACTIVE_VECTOR,
  input wire logic EXT_EVENT,
  input wire logic SEND_EVENT_INSTR,
  input wire logic WAIT_FOR_EVENT,
  input wire logic PSV_TAKEN,
  input wire logic TICK_EVENT,
  input wire logic TICK_TAKEN,
  input wire logic HANDLER_EXIT_TO_THREAD,
  output logic PSV_PENDING,
  output logic TICK_PENDING,
  output logic SYSTEM_RESET_REQUEST,
  output logic WAKE_UP,
  output logic EVENT_LATCHED,
  output logic DEEP_SLEEP_SELECT,
  output logic SLEEP_ON_EXIT,
  output logic SLEEP_ON_EXIT_REQ,
  output logic IRQ
);

  // address phase capture
  logic wr_pend;
  logic [11:0] addr_q;
  logic psv_pend;
  logic tick_pend;
  logic [2:0] lpc;
  logic ev_latch;
  logic [3:0] stat;
  logic [3:0] mask;
  logic ev_sync1;
  logic ev_sync2;
  logic ev_prev;
  logic pend_prev;
  logic reset_req;

  wire take = HSEL && HREADY && HTRANS[1];
  wire sel_ics = addr_q == `SCB_OFS_ICS;
  wire sel_airc = addr_q == `SCB_OFS_AIRC;
  wire sel_lpc = addr_q == `SCB_OFS_LPC;
  wire sel_stat = addr_q == `SCB_OFS_IRQ_STAT;
  wire sel_mask = addr_q == `SCB_OFS_IRQ_MASK;
  wire wr_ics = wr_pend && sel_ics;
  wire key_ok = HWDATA[31:16] == `SCB_WRITE_KEY;
  wire wr_airc = wr_pend && sel_airc && key_ok;
  wire wr_lpc = wr_pend && sel_lpc;

  // read side decodes the address phase itself, so the data stands during the data phase
  // with no wait state; live core inputs are therefore seen as they were in that phase
  wire [11:0] raddr = {HADDR[11:2], 2'b00};
  wire rd_take = take && !HWRITE;
  wire rsel_ics = raddr == `SCB_OFS_ICS;
  wire rsel_airc = raddr == `SCB_OFS_AIRC;
  wire rsel_lpc = raddr == `SCB_OFS_LPC;
  wire rsel_stat = raddr == `SCB_OFS_IRQ_STAT;
  wire rsel_mask = raddr == `SCB_OFS_IRQ_MASK;

  // ics write strobes; simultaneous set and clear is undefined, set is given priority
  wire psv_set = wr_ics && HWDATA[`SCB_BIT_PSV_SET];
  wire psv_clr = wr_ics && HWDATA[`SCB_BIT_PSV_CLR];
  wire tick_set = wr_ics && HWDATA[`SCB_BIT_TICK_SET];
  wire tick_clr = wr_ics && HWDATA[`SCB_BIT_TICK_CLR];
  wire reset_hit = wr_airc && HWDATA[`SCB_BIT_SYS_RESET];

  // pending sources that may wake: disabled ones only with event_on_pending
  wire event_on_pending = lpc[`SCB_BIT_EV_ON_PEND - 2];
  wire pend_wakeable = IRQ_PENDING_ANY || psv_pend || tick_pend
                       || (event_on_pending && IRQ_PENDING_DISABLED);
  wire pend_rise = pend_wakeable && !pend_prev;
  wire ext_rise = ev_sync2 && !ev_prev;
  wire wake_ev = pend_rise || ext_rise || SEND_EVENT_INSTR;

  // read views; key field and write-only bits read zero
  // bits 31:29, 27, 25:23, 21:18 and 11:6 are reserved or write-only and read zero
  wire [31:0] ics_view = {3'h0, psv_pend, 1'b0, tick_pend, 3'h0,
                          IRQ_PENDING_ANY, 4'h0, PENDING_VECTOR, 6'h0,
                          ACTIVE_VECTOR};
  wire [31:0] airc_view = {16'h0, BYTE_ORDER, 15'h0};
  // lpc holds bit 4, bit 2 and bit 1 packed as [2], [1] and [0]
  wire [31:0] lpc_view = {27'h0, lpc[2], 1'b0, lpc[1], lpc[0], 1'b0};
  // unmapped offsets read zero
  wire [31:0] rd_mux = rsel_ics ? ics_view :
                       rsel_airc ? airc_view :
                       rsel_lpc ? lpc_view :
                       rsel_stat ? {28'h0, stat} :
                       rsel_mask ? {28'h0, mask} : 32'h0;

  wire [3:0] ev_vec = {tick_set & ~tick_pend, psv_set & ~psv_pend,
                       wake_ev, reset_hit};

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PSV_PENDING = psv_pend;
  assign TICK_PENDING = tick_pend;
  assign SYSTEM_RESET_REQUEST = reset_req;
  assign EVENT_LATCHED = ev_latch;
  assign DEEP_SLEEP_SELECT = lpc[1];
  assign SLEEP_ON_EXIT = lpc[0];
  assign SLEEP_ON_EXIT_REQ = lpc[0] && HANDLER_EXIT_TO_THREAD;
  assign IRQ = |(stat & mask);

  // bus phase tracking
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_pend <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      // a write lands at the edge that ends its data phase, when hwdata stands
      wr_pend <= take && HWRITE;
      if (take)
        addr_q <= {HADDR[11:2], 2'b00};
    end
  end

  // read data registered in the address phase cycle so it stands in the data phase
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      HRDATA <= 32'h0;
    else if (rd_take)
      HRDATA <= rd_mux;
  end

  // exception pending bits; hardware clear when the core takes the exception
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      psv_pend <= 1'b0;
      tick_pend <= 1'b0;
    end
    else
    begin
      if (psv_set)
        psv_pend <= 1'b1;
      else if (psv_clr || PSV_TAKEN)
        psv_pend <= 1'b0;
      if (tick_set || TICK_EVENT)
        tick_pend <= 1'b1;
      else if (tick_clr || TICK_TAKEN)
        tick_pend <= 1'b0;
    end
  end

  // keyed control and low-power control; reset request is a held level
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      reset_req <= 1'b0;
      lpc <= `SCB_LPC_RESET;
    end
    else
    begin
      if (reset_hit)
        reset_req <= 1'b1;
      if (wr_lpc)
        lpc <= {HWDATA[`SCB_BIT_EV_ON_PEND], HWDATA[`SCB_BIT_DEEP_SLEEP],
                HWDATA[`SCB_BIT_SLEEP_EXIT]};
    end
  end

  // external event synchroniser and edge history
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ev_sync1 <= 1'b0;
      ev_sync2 <= 1'b0;
      ev_prev <= 1'b0;
      pend_prev <= 1'b0;
    end
    else
    begin
      ev_sync1 <= EXT_EVENT;
      ev_sync2 <= ev_sync1;
      ev_prev <= ev_sync2;
      pend_prev <= pend_wakeable;
    end
  end

  // event latch: wakes a waiting core one cycle later, else held for the next wait
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ev_latch <= 1'b0;
      WAKE_UP <= 1'b0;
    end
    else
    begin
      WAKE_UP <= WAIT_FOR_EVENT && (wake_ev || ev_latch);
      if (WAIT_FOR_EVENT)
        ev_latch <= 1'b0;
      else if (wake_ev)
        ev_latch <= 1'b1;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_stat
      always_ff @(posedge SYS_CLK or posedge SYS_RST)
      begin
        if (SYS_RST)
          stat[gi] <= 1'b0;
        else if (ev_vec[gi])
          stat[gi] <= 1'b1;
        else if (wr_pend && sel_stat && HWDATA[gi])
          stat[gi] <= 1'b0;
      end
    end
  endgenerate

  // interrupt mask
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      mask <= 4'h0;
    else if (wr_pend && sel_mask)
      mask <= HWDATA[3:0];
  end

endmodule : scb_regs

// File: hdl/scb_map.svh
// Purpose: register offsets, field positions, reset values and keys of the control block
// Assumes: 32-bit word registers on AHB-Lite, byte addresses below
// Notes: definitions only
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
`define SCB_OFS_ICS 12'h004
`define SCB_OFS_AIRC 12'h00c
`define SCB_OFS_LPC 12'h010
`define SCB_OFS_IRQ_STAT 12'h020
`define SCB_OFS_IRQ_MASK 12'h024
`define SCB_BIT_PSV_SET 28
`define SCB_BIT_PSV_CLR 27
`define SCB_BIT_TICK_SET 26
`define SCB_BIT_TICK_CLR 25
`define SCB_BIT_IRQ_PEND 22
`define SCB_BIT_BYTE_ORDER 15
`define SCB_BIT_SYS_RESET 2
`define SCB_BIT_DBG_CLR 1
`define SCB_BIT_EV_ON_PEND 4
`define SCB_BIT_DEEP_SLEEP 2
`define SCB_BIT_SLEEP_EXIT 1
`define SCB_WRITE_KEY 16'h05fa
`define SCB_LPC_RESET 3'h0
`define SCB_LPC_WMASK 32'h0000_0016
`endif

// File: hdl/scb_pkg.sv
// Purpose: types shared by the control block
// Assumes: nothing beyond the map header
// Notes: status bit positions of the interrupt status register
package scb_pkg;
  typedef enum logic [1:0]
  {
    SCB_EV_RESET_REQ,
    SCB_EV_WAKE,
    SCB_EV_PSV_PEND,
    SCB_EV_TICK_PEND
  } scb_event_t;
  typedef logic [5:0] scb_vector_t;
endpackage : scb_pkg

// File: testbench/scb_props.sv
// Purpose: checker for the control block outputs
// Assumes: one clock, zero wait state bus
// Notes: bound to scb_regs below
`timescale 1ns/1ps
module scb_props
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] HWDATA,
  input wire logic SEND_EVENT_INSTR,
  input wire logic WAIT_FOR_EVENT,
  input wire logic TICK_EVENT,
  input wire logic HANDLER_EXIT_TO_THREAD,
  input wire logic TICK_PENDING,
  input wire logic SYSTEM_RESET_REQUEST,
  input wire logic WAKE_UP,
  input wire logic EVENT_LATCHED,
  input wire logic SLEEP_ON_EXIT,
  input wire logic SLEEP_ON_EXIT_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // wake steps: an event while waiting, or a latched event met by a wait
  sequence s_sev_wait; SEND_EVENT_INSTR && WAIT_FOR_EVENT; endsequence
  sequence s_latch_wait; EVENT_LATCHED && WAIT_FOR_EVENT; endsequence
  property p_key;
    $rose(SYSTEM_RESET_REQUEST) |-> ($past(HWDATA[31:16]) == 16'h05fa) && $past(HWDATA[2]);
  endproperty
  property p_sticky; SYSTEM_RESET_REQUEST |=> SYSTEM_RESET_REQUEST; endproperty
  property p_soe; SLEEP_ON_EXIT_REQ == (SLEEP_ON_EXIT && HANDLER_EXIT_TO_THREAD); endproperty
  property p_sev; s_sev_wait |=> WAKE_UP; endproperty
  property p_latch; SEND_EVENT_INSTR && !WAIT_FOR_EVENT |=> EVENT_LATCHED; endproperty
  property p_lwake; s_latch_wait |-> ##[0:2] WAKE_UP; endproperty
  property p_cause; $rose(WAKE_UP) |-> $past(WAIT_FOR_EVENT); endproperty
  property p_tick; TICK_EVENT |=> TICK_PENDING; endproperty
  a_key: assert property (p_key) else $error("reset request without key");
  a_sticky: assert property (p_sticky) else $error("reset request dropped");
  a_soe: assert property (p_soe) else $error("sleep on exit wrong");
  a_sev: assert property (p_sev) else $error("send event did not wake");
  a_latch: assert property (p_latch) else $error("event not latched");
  a_lwake: assert property (p_lwake) else $error("latched event did not wake");
  a_cause: assert property (p_cause) else $error("wake while not waiting");
  a_tick: assert property (p_tick) else $error("tick not pending");
endmodule : scb_props
bind scb_regs scb_props u_props (.SYS_CLK, .SYS_RST, .HWDATA, .SEND_EVENT_INSTR,
  .WAIT_FOR_EVENT, .TICK_EVENT, .HANDLER_EXIT_TO_THREAD, .TICK_PENDING,
  .SYSTEM_RESET_REQUEST, .WAKE_UP, .EVENT_LATCHED, .SLEEP_ON_EXIT, .SLEEP_ON_EXIT_REQ);

// File: testbench/scb_core_model.sv
// Purpose: core side model: waits for events, takes the pending pendable-service exception
// Assumes: same clock as the block
// Notes: stays waiting until woken, never wakes itself
`timescale 1ns/1ps
module scb_core_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_cmd,
  input wire logic take_cmd,
  input wire logic wake,
  input wire logic psv_pend,
  output logic wait_for_event,
  output logic psv_taken
);
  // taken is a single pulse so one entry clears one pending state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_for_event <= 1'b0;
      psv_taken <= 1'b0;
    end
    else
    begin
      wait_for_event <= !wake && (sleep_cmd || wait_for_event);
      psv_taken <= take_cmd && psv_pend && !psv_taken;
    end
  end
endmodule : scb_core_model

// File: testbench/tb.sv
// Purpose: self-checking bench for the control registers
// Assumes: read data stands in the data phase and is taken at its closing edge
// Notes: expected read results are queued and compared by a watcher
`timescale 1ns/1ps
`include "scb_map.svh"
module tb import scb_pkg::*;;
  logic SYS_CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP, rv, sleep_cmd, take_cmd;
  logic [31:0] HADDR, HWDATA, HRDATA, q[$];
  logic [1:0] HTRANS;
  scb_vector_t PENDING_VECTOR, ACTIVE_VECTOR;
  logic IRQ_PENDING_ANY, IRQ_PENDING_DISABLED, EXT_EVENT, SEND_EVENT_INSTR, TICK_EVENT;
  logic HANDLER_EXIT_TO_THREAD, WAIT_FOR_EVENT, PSV_TAKEN, PSV_PENDING, TICK_PENDING;
  logic SYSTEM_RESET_REQUEST, WAKE_UP, EVENT_LATCHED, DEEP_SLEEP_SELECT, SLEEP_ON_EXIT, IRQ;
  logic TICK_TAKEN;
  int err_count, n_compared, cyc;
  scb_regs uut (.SYS_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .IRQ_PENDING_ANY, .IRQ_PENDING_DISABLED,
    .PENDING_VECTOR, .ACTIVE_VECTOR, .EXT_EVENT, .SEND_EVENT_INSTR, .WAIT_FOR_EVENT, .PSV_TAKEN,
    .TICK_EVENT, .TICK_TAKEN, .HANDLER_EXIT_TO_THREAD, .PSV_PENDING, .TICK_PENDING,
    .SYSTEM_RESET_REQUEST, .WAKE_UP, .EVENT_LATCHED, .DEEP_SLEEP_SELECT, .SLEEP_ON_EXIT,
    .SLEEP_ON_EXIT_REQ(), .IRQ);
  scb_core_model u_core (.clk(SYS_CLK), .rst(SYS_RST), .sleep_cmd, .take_cmd, .wake(WAKE_UP),
    .psv_pend(PSV_PENDING), .wait_for_event(WAIT_FOR_EVENT), .psv_taken(PSV_TAKEN));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // single transfer; hready is waited on although it never drops
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h0, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rv <= !w;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rv <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic stop_test;
    $display("TB: %0d mismatches in %0d compares", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] ics(input logic p, input logic t);
    return {3'h0, p, 1'b0, t, 3'h0, IRQ_PENDING_ANY, 4'h0, PENDING_VECTOR, 6'h0, ACTIVE_VECTOR};
  endfunction : ics
  initial
  begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // watcher: read data is taken at the edge that closes the data phase
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (rv) chk(HRDATA, q.pop_front());
    if (cyc == 3000)
    begin
      err_count++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(64643));
    {HSEL, HWRITE, rv, sleep_cmd, take_cmd, IRQ_PENDING_ANY, IRQ_PENDING_DISABLED} = '0;
    {EXT_EVENT, SEND_EVENT_INSTR, TICK_EVENT, HANDLER_EXIT_TO_THREAD, HTRANS} = '0;
    {HADDR, HWDATA, PENDING_VECTOR, ACTIVE_VECTOR, TICK_TAKEN} = '0;
    SYS_RST = 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    HSEL <= 1'b1;
    repeat (4)
    begin
      IRQ_PENDING_ANY <= 1'($urandom);
      PENDING_VECTOR <= 6'($urandom);
      ACTIVE_VECTOR <= 6'(16 + $urandom_range(31));
      @(posedge SYS_CLK);
      rd(`SCB_OFS_ICS, ics(0, 0));
    end
    rd(`SCB_OFS_AIRC, 32'h0);
    xfer(1'b1, `SCB_OFS_LPC, 32'hffff_ffff);
    rd(`SCB_OFS_LPC, `SCB_LPC_WMASK);
    chk(DEEP_SLEEP_SELECT, 1);
    HANDLER_EXIT_TO_THREAD <= 1'b1;
    xfer(1'b1, `SCB_OFS_LPC, 32'h10);
    HANDLER_EXIT_TO_THREAD <= 1'b0;
    IRQ_PENDING_DISABLED <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk({DEEP_SLEEP_SELECT, SLEEP_ON_EXIT, EVENT_LATCHED}, 3'b001);
    $display("TB: low power control done");
    for (int k = 0; k < 3; k++)
    begin
      sleep_cmd <= 1'b1;
      @(posedge SYS_CLK);
      sleep_cmd <= 1'b0;
      SEND_EVENT_INSTR <= (k == 1);
      EXT_EVENT <= (k == 2);
      @(posedge SYS_CLK);
      SEND_EVENT_INSTR <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      chk({WAIT_FOR_EVENT, EVENT_LATCHED}, 2'b00);
      EXT_EVENT <= 1'b0;
    end
    xfer(1'b1, `SCB_OFS_IRQ_MASK, 32'h2);
    @(posedge SYS_CLK);
    chk(IRQ, 1);
    xfer(1'b1, `SCB_OFS_IRQ_STAT, 32'h2);
    @(posedge SYS_CLK);
    chk(IRQ, 0);
    $display("TB: wake and interrupt done");
    // one write per set or clear bit, zero writes in between must not disturb
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, `SCB_OFS_ICS, 32'h1 << (28 - 2 * k));
      xfer(1'b1, `SCB_OFS_ICS, 32'h0);
      rd(`SCB_OFS_ICS, ics(k == 0, k == 1));
      xfer(1'b1, `SCB_OFS_ICS, 32'h1 << (27 - 2 * k));
      rd(`SCB_OFS_ICS, ics(0, 0));
    end
    TICK_EVENT <= 1'b1;
    xfer(1'b1, `SCB_OFS_ICS, 32'h1 << 28);
    TICK_EVENT <= 1'b0;
    take_cmd <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk({PSV_PENDING, TICK_PENDING}, 2'b01);
    TICK_TAKEN <= 1'b1;
    @(posedge SYS_CLK);
    TICK_TAKEN <= 1'b0;
    @(posedge SYS_CLK);
    chk(TICK_PENDING, 0);
    $display("TB: pending bits done");
    xfer(1'b1, `SCB_OFS_AIRC, 32'h05fb_0004);
    xfer(1'b1, 12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    chk(SYSTEM_RESET_REQUEST, 0);
    xfer(1'b1, `SCB_OFS_AIRC, {`SCB_WRITE_KEY, 16'h0004});
    rd(`SCB_OFS_AIRC, 32'h0);
    chk(SYSTEM_RESET_REQUEST, 1);
    $display("TB: reset control done");
    stop_test();
  end
endmodule : tb
